// file: bench/tb_swd_top.sv
// Purpose: self-checking bench of the software watchdog through its register port
// Assumes: synchronous active-low reset, read data stands one cycle after the read strobe
// Notes: window edges are kept one cycle inside the arm life to stay clear of its last cycle
`timescale 1ns/1ns
`include "swd_defines.svh"

module tb_swd_top
  import swd_pkg::*;
;
  logic mclk;
  logic rst_n;
  swd_bus_req_t bus_req;
  logic [7:0] bus_rdata;
  logic wd_timeout;
  logic wd_reset_req;
  logic irq;
  int err_total;
  int num_checks;

  swd_top uut (
    .mclk(mclk),
    .rst_n(rst_n),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .wd_timeout(wd_timeout),
    .wd_reset_req(wd_reset_req),
    .irq(irq)
  );

  // ==========================================================================
  // clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    #300000;
    err_total++;
    summarize();
  end

  // ==========================================================================
  // shared tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    #1;
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] msk, input logic [7:0] exp,
                        input string what);
    #1;
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1;
    check(what, bus_rdata & msk, exp);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    for (int a = 0; a < 8; a++) begin
      chk_rd(8'(a), 8'hff, 8'h00, "reg after reset");
    end
    chk_rd(8'h08, 8'hff, 8'h00, "unmapped read");
    wr(`SWD_OFF_COUNT_LO, 8'h55);
    chk_rd(`SWD_OFF_COUNT_LO, 8'hff, 8'h00, "count write ignored");
    check("timeout out", {wd_timeout, wd_reset_req, irq}, 16'h0000);
  endtask

  task automatic t_regs();
    wr(`SWD_OFF_RELOAD, 8'ha5);
    chk_rd(`SWD_OFF_RELOAD, 8'hff, 8'ha5, "reload rw");
    wr(`SWD_OFF_RELOAD, 8'h5a);
    chk_rd(`SWD_OFF_RELOAD, 8'hff, 8'h5a, "reload rw");
    wr(`SWD_OFF_IRQ_PRIO_FIRST, 8'h7f);
    chk_rd(`SWD_OFF_IRQ_PRIO_FIRST, 8'hff, 8'h3f, "prio status bit");
  endtask

  task automatic t_count();
    do_reset();
    wr(`SWD_OFF_IRQ_EN_SECOND, 8'h40);
    repeat (251) @(posedge mclk);
    chk_rd(`SWD_OFF_COUNT_LO, 8'hff, 8'h0a, "count base rate");
    wr(`SWD_OFF_IRQ_EN_SECOND, 8'h00);
    wr(`SWD_OFF_IRQ_EN_FIRST, 8'h00);
    repeat (236) @(posedge mclk);
    chk_rd(`SWD_OFF_COUNT_LO, 8'hff, 8'h14, "count keeps running");
    chk_rd(`SWD_OFF_EVT_STATUS, 8'h08, 8'h08, "started event");
    do_reset();
    wr(`SWD_OFF_RELOAD, 8'h80);
    wr(`SWD_OFF_IRQ_EN_SECOND, 8'h40);
    repeat (3 * 384 + 191) @(posedge mclk);
    chk_rd(`SWD_OFF_COUNT_LO, 8'hff, 8'h03, "count extra prescaler");
  endtask

  task automatic t_window();
    do_reset();
    wr(`SWD_OFF_RELOAD, 8'h12);
    wr(`SWD_OFF_IRQ_EN_SECOND, 8'h40);
    chk_rd(`SWD_OFF_EVT_STATUS, 8'hff, 8'h08, "status after start");
    // arm, let it lapse, then set start too late
    wr(`SWD_OFF_IRQ_EN_FIRST, 8'h40);
    repeat (9) @(posedge mclk);
    chk_rd(`SWD_OFF_IRQ_EN_FIRST, 8'h40, 8'h40, "arm inside life");
    repeat (2) @(posedge mclk);
    chk_rd(`SWD_OFF_IRQ_EN_FIRST, 8'h40, 8'h00, "arm self clear");
    wr(`SWD_OFF_IRQ_EN_SECOND, 8'h40);
    repeat (9) @(posedge mclk);
    chk_rd(`SWD_OFF_IRQ_EN_SECOND, 8'h40, 8'h40, "start inside life");
    repeat (2) @(posedge mclk);
    chk_rd(`SWD_OFF_IRQ_EN_SECOND, 8'h40, 8'h00, "start self clear");
    chk_rd(`SWD_OFF_COUNT_HI, 8'hff, 8'h00, "no reload late");
    chk_rd(`SWD_OFF_EVT_STATUS, 8'h06, 8'h04, "missed event");
    // arm, then start inside the window, one cycle before the arm's last cycle
    wr(`SWD_OFF_IRQ_EN_FIRST, 8'h40);
    repeat (10) @(posedge mclk);
    wr(`SWD_OFF_IRQ_EN_SECOND, 8'h40);
    chk_rd(`SWD_OFF_COUNT_LO, 8'hff, 8'h00, "reload low byte");
    chk_rd(`SWD_OFF_COUNT_HI, 8'hff, 8'h12, "reload high byte");
    chk_rd(`SWD_OFF_IRQ_EN_FIRST, 8'h40, 8'h00, "arm consumed");
    chk_rd(`SWD_OFF_EVT_STATUS, 8'h06, 8'h02, "refresh event");
  endtask

  task automatic t_timeout();
    int n;
    do_reset();
    wr(`SWD_OFF_EVT_MASK, 8'h01);
    wr(`SWD_OFF_RELOAD, 8'h7c);
    wr(`SWD_OFF_IRQ_EN_FIRST, 8'h40);
    wr(`SWD_OFF_IRQ_EN_SECOND, 8'h40);
    n = 0;
    while (wd_timeout !== 1'b1 && n < 7000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("cycles to terminal", 16'(n >= 6096 && n <= 6144), 16'h0001);
    check("reset request", 16'(wd_reset_req), 16'h0001);
    @(posedge mclk);
    #1;
    check("irq on timeout", 16'(irq), 16'h0001);
    chk_rd(`SWD_OFF_IRQ_PRIO_FIRST, 8'h40, 8'h40, "prio timeout bit");
    chk_rd(`SWD_OFF_COUNT_HI, 8'hff, 8'h7c, "terminal high");
    chk_rd(`SWD_OFF_COUNT_LO, 8'hff, 8'hff, "terminal low");
    repeat (26) @(posedge mclk);
    #1;
    check("timeout falls", {wd_timeout, wd_reset_req}, 16'h0000);
    chk_rd(`SWD_OFF_EVT_STATUS, 8'h01, 8'h01, "timeout event");
    @(posedge mclk);
    #1;
    check("irq after clear", 16'(irq), 16'h0000);
    do_reset();
    check("out after reset", {wd_timeout, irq}, 16'h0000);
    repeat (30) @(posedge mclk);
    chk_rd(`SWD_OFF_COUNT_LO, 8'hff, 8'h00, "halted by reset");
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    err_total = 0;
    num_checks = 0;
    rst_n = 1'b0;
    bus_req = '0;
    do_reset();
    t_reset();
    t_regs();
    t_count();
    t_window();
    t_timeout();
    summarize();
  end
endmodule

// file: src/swd_defines.svh
// Purpose: offsets, field positions, reset values and counts of the software watchdog
// Assumes: one 8-bit register per address on the plain register port
// Notes: included by its bare name
`ifndef SWD_DEFINES_SVH
`define SWD_DEFINES_SVH

// ==========================================================================
// register offsets
`define SWD_OFF_IRQ_EN_FIRST 8'h00
`define SWD_OFF_IRQ_EN_SECOND 8'h01
`define SWD_OFF_IRQ_PRIO_FIRST 8'h02
`define SWD_OFF_RELOAD 8'h03
`define SWD_OFF_COUNT_LO 8'h04
`define SWD_OFF_COUNT_HI 8'h05
`define SWD_OFF_EVT_STATUS 8'h06
`define SWD_OFF_EVT_MASK 8'h07

// ==========================================================================
// field positions
`define SWD_BIT_ARM 6
`define SWD_BIT_START 6
`define SWD_BIT_TIMEOUT 6
`define SWD_BIT_PRESC_SEL 7
`define SWD_EVT_TIMEOUT 0
`define SWD_EVT_REFRESH 1
`define SWD_EVT_MISSED 2
`define SWD_EVT_STARTED 3

// ==========================================================================
// reset values
`define SWD_RST_REG8 8'h00
`define SWD_RST_COUNT 16'h0000

// ==========================================================================
// counts
`define SWD_TERMINAL 16'h7cff
`define SWD_WINDOW_CYC 12
`define SWD_PRESC_BASE 24
`define SWD_PRESC_EXTRA 16

`endif

// file: src/swd_pkg.sv
// Purpose: types of the software watchdog
// Assumes: nothing
// Notes: constants live in swd_defines.svh
package swd_pkg;

  // ==========================================================================
  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } swd_bus_req_t;

  // ==========================================================================
  // watchdog run state
  typedef enum logic {
    SWD_STOPPED = 1'b0,
    SWD_RUNNING = 1'b1
  } swd_run_t;

endpackage

// file: src/swd_top.sv
// Purpose: software watchdog with timed two-flag refresh and event interrupt
// Assumes: bus strobes one cycle long, never both at once, synchronous to mclk
// Notes: only rst_n stops the watchdog once it runs
// How it works
// - a 16-bit counter steps once every 24 clocks, or every 384 with the extra prescaler.
// - after reset the watchdog is stopped and counter and all its registers are zero.
// - once running no software write can stop it; only reset does.
// - setting the start/refresh flag (bit 6 of the second enable register) starts it.
// - at count 0x7cff the timeout signal rises, shows in priority bit 6 and asks for reset.
// - the timeout signal falls on reset or as soon as the counter moves on.
// - if the start/refresh flag is not set within the 12 clocks, arm clears with no reload.
// - a start/refresh set while armed reloads the counter and clears the arm flag.
// - the arm flag (bit 6 of the first enable register) self-clears 12 clocks after set.
// - the start/refresh flag self-clears 12 clocks after set.
// - bit 6 of the first priority register reads back the watchdog timeout status.
// - reload bit 7 adds a divide-by-16 stage to the watchdog clock.
// - reload bits 6..0 go into the counter high byte on each valid refresh.
// - the reload register can be written and read at any time.
`timescale 1ns/1ns
`include "swd_defines.svh"

module swd_top
  import swd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire swd_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  output logic wd_timeout,
  output logic wd_reset_req,
  output logic irq
);

  localparam logic [8:0] PRESC_FAST_LAST = 9'(`SWD_PRESC_BASE - 1);
  localparam logic [8:0] PRESC_SLOW_LAST = 9'(`SWD_PRESC_BASE * `SWD_PRESC_EXTRA - 1);
  localparam logic [3:0] WIN_LAST = 4'(`SWD_WINDOW_CYC - 1);

  // ==========================================================================
  // helpers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic [3:0] age_step(input logic [3:0] a);
    return (a == WIN_LAST) ? a : 4'(a + 4'h1);
  endfunction

  logic [7:0] irq_enable_first_q, irq_enable_second_q, ip0_q, reload_q, mask_q, status_q, rdata_q;
  logic [7:0] status_d, mask_d, rd_mux;
  logic [15:0] cnt_q, cnt_d;
  logic [8:0] presc_q;
  logic [3:0] arm_age_q, start_age_q, evt;
  logic timeout_q, irq_q;
  swd_run_t run_q;

  logic wr_irq_enable_first, wr_irq_enable_second, wr_ip0, wr_rel, wr_mask, rd_status;
  logic arm_q, start_q, arm_set, start_set, refresh, arm_expire, presc_last, tick;

  // ==========================================================================
  // decode
  assign wr_irq_enable_first = bus_req.wr && hit(bus_req.addr, `SWD_OFF_IRQ_EN_FIRST);
  assign wr_irq_enable_second = bus_req.wr && hit(bus_req.addr, `SWD_OFF_IRQ_EN_SECOND);
  assign wr_ip0 = bus_req.wr && hit(bus_req.addr, `SWD_OFF_IRQ_PRIO_FIRST);
  assign wr_rel = bus_req.wr && hit(bus_req.addr, `SWD_OFF_RELOAD);
  assign wr_mask = bus_req.wr && hit(bus_req.addr, `SWD_OFF_EVT_MASK);
  assign rd_status = bus_req.rd && hit(bus_req.addr, `SWD_OFF_EVT_STATUS);

  assign arm_q = irq_enable_first_q[`SWD_BIT_ARM];
  assign start_q = irq_enable_second_q[`SWD_BIT_START];
  assign arm_set = wr_irq_enable_first && bus_req.wdata[`SWD_BIT_ARM];
  assign start_set = wr_irq_enable_second && bus_req.wdata[`SWD_BIT_START];
  assign refresh = start_set && arm_q;
  assign arm_expire = arm_q && (arm_age_q == WIN_LAST) && !wr_irq_enable_first && !start_set;

  // ==========================================================================
  // arm flag with 12-clock life
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_enable_first_q <= `SWD_RST_REG8;
      arm_age_q <= 4'h0;
    end else if (wr_irq_enable_first) begin
      irq_enable_first_q <= bus_req.wdata;
      arm_age_q <= 4'h0;
    end else begin
      if (start_set) begin
        irq_enable_first_q[`SWD_BIT_ARM] <= 1'b0;
      end else if (arm_expire) begin
        irq_enable_first_q[`SWD_BIT_ARM] <= 1'b0;
      end
      if (arm_q) begin
        arm_age_q <= age_step(arm_age_q);
      end
    end
  end

  // ==========================================================================
  // start/refresh flag with 12-clock life
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_enable_second_q <= `SWD_RST_REG8;
      start_age_q <= 4'h0;
    end else if (wr_irq_enable_second) begin
      irq_enable_second_q <= bus_req.wdata;
      start_age_q <= 4'h0;
    end else begin
      if (start_q && start_age_q == WIN_LAST) begin
        irq_enable_second_q[`SWD_BIT_START] <= 1'b0;
      end
      if (start_q) begin
        start_age_q <= age_step(start_age_q);
      end
    end
  end

  // ==========================================================================
  // run state
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      run_q <= SWD_STOPPED;
    end else begin
      unique case (run_q)
        SWD_STOPPED: begin
          if (start_set) begin
            run_q <= SWD_RUNNING;
          end
        end
        SWD_RUNNING: begin
          run_q <= SWD_RUNNING;
        end
      endcase
    end
  end

  // ==========================================================================
  // prescaler and counter
  assign presc_last = presc_q >= (reload_q[`SWD_BIT_PRESC_SEL] ? PRESC_SLOW_LAST
                                                                : PRESC_FAST_LAST);
  assign tick = (run_q == SWD_RUNNING) && presc_last;

  always_ff @(posedge mclk) begin
    if (!rst_n || refresh || run_q == SWD_STOPPED || presc_last) begin
      presc_q <= 9'h000;
    end else begin
      presc_q <= 9'(presc_q + 9'h001);
    end
  end

  always_comb begin
    cnt_d = cnt_q;
    if (refresh) begin
      cnt_d = {1'b0, reload_q[6:0], 8'h00};
    end else if (tick) begin
      cnt_d = 16'(cnt_q + 16'h0001);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q <= `SWD_RST_COUNT;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // timeout follows the counter state, so any change of count drops it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      timeout_q <= 1'b0;
    end else begin
      timeout_q <= (cnt_d == `SWD_TERMINAL);
    end
  end

  // ==========================================================================
  // software registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reload_q <= `SWD_RST_REG8;
    end else if (wr_rel) begin
      reload_q <= bus_req.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ip0_q <= `SWD_RST_REG8;
    end else if (wr_ip0) begin
      ip0_q <= bus_req.wdata;
    end
  end

  assign mask_d = wr_mask ? bus_req.wdata : mask_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mask_q <= `SWD_RST_REG8;
    end else begin
      mask_q <= mask_d;
    end
  end

  // ==========================================================================
  // event status, read clears, a new event wins over the clear
  always_comb begin
    evt = 4'h0;
    evt[`SWD_EVT_TIMEOUT] = (cnt_d == `SWD_TERMINAL) && !timeout_q;
    evt[`SWD_EVT_REFRESH] = refresh;
    evt[`SWD_EVT_MISSED] = arm_expire;
    evt[`SWD_EVT_STARTED] = start_set && (run_q == SWD_STOPPED);
    status_d = (rd_status ? 8'h00 : status_q) | {4'h0, evt};
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status_q <= `SWD_RST_REG8;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q <= |(status_d & mask_d);
    end
  end

  // ==========================================================================
  // read port
  always_comb begin
    unique case (bus_req.addr)
      `SWD_OFF_IRQ_EN_FIRST: rd_mux = irq_enable_first_q;
      `SWD_OFF_IRQ_EN_SECOND: rd_mux = irq_enable_second_q;
      `SWD_OFF_IRQ_PRIO_FIRST: rd_mux = {ip0_q[7], timeout_q, ip0_q[5:0]};
      `SWD_OFF_RELOAD: rd_mux = reload_q;
      `SWD_OFF_COUNT_LO: rd_mux = cnt_q[7:0];
      `SWD_OFF_COUNT_HI: rd_mux = cnt_q[15:8];
      `SWD_OFF_EVT_STATUS: rd_mux = status_q;
      `SWD_OFF_EVT_MASK: rd_mux = mask_q;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || !bus_req.rd) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_mux;
    end
  end

  assign bus_rdata = rdata_q;
  assign wd_timeout = timeout_q;
  assign wd_reset_req = timeout_q;
  assign irq = irq_q;

  // ==========================================================================
  // checks
  logic [8:0] gap_q;
  logic gap_ok_q;
  logic arm_touch, start_touch;
  localparam logic [8:0] GAP_FAST = 9'd23;
  localparam logic [8:0] GAP_SLOW = 9'd383;

  assign arm_touch = wr_irq_enable_first || start_set;
  assign start_touch = wr_irq_enable_second;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gap_q <= 9'h000;
      gap_ok_q <= 1'b0;
    end else if (cnt_d != cnt_q || refresh || (start_set && run_q == SWD_STOPPED)) begin
      gap_q <= 9'h000;
      gap_ok_q <= !wr_rel;
    end else begin
      gap_q <= 9'(gap_q + 9'h001);
      if (wr_rel) begin
        gap_ok_q <= 1'b0;
      end
    end
  end

  AST_STEP_PERIOD: assert property (@(posedge mclk) disable iff (!rst_n)
    (tick && !refresh && gap_ok_q) |->
      gap_q == (reload_q[`SWD_BIT_PRESC_SEL] ? GAP_SLOW : GAP_FAST))
    else $error("counter stepped at the wrong prescaler count");

  AST_RESET_CLEAR: assert property (@(posedge mclk)
    !rst_n |=> (run_q == SWD_STOPPED && cnt_q == 16'h0000 && reload_q == 8'h00
                && irq_enable_first_q == 8'h00 && irq_enable_second_q == 8'h00 && !wd_timeout))
    else $error("watchdog state not cleared by reset");

  AST_NO_STOP: assert property (@(posedge mclk) disable iff (!rst_n)
    run_q == SWD_RUNNING |=> run_q == SWD_RUNNING)
    else $error("running watchdog stopped without reset");

  AST_START: assert property (@(posedge mclk) disable iff (!rst_n)
    (run_q == SWD_STOPPED && start_set) |=> run_q == SWD_RUNNING)
    else $error("start flag did not start the watchdog");

  AST_TIMEOUT: assert property (@(posedge mclk) disable iff (!rst_n)
    cnt_q == `SWD_TERMINAL |-> (wd_timeout && wd_reset_req))
    else $error("terminal count without timeout and reset request");

  AST_TIMEOUT_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    (cnt_q == `SWD_TERMINAL && bus_req.rd && bus_req.addr == `SWD_OFF_IRQ_PRIO_FIRST) |=>
      bus_rdata[`SWD_BIT_TIMEOUT])
    else $error("terminal count not shown in priority status bit");

  AST_TIMEOUT_DROP: assert property (@(posedge mclk) disable iff (!rst_n)
    (wd_timeout && cnt_d != cnt_q) |=> !wd_timeout)
    else $error("timeout held after counter moved");

  AST_ARM_WINDOW: assert property (@(posedge mclk) disable iff (!rst_n)
    (arm_q && arm_age_q == WIN_LAST && !arm_touch) |=> !arm_q)
    else $error("arm flag outlived its 12 clocks");

  AST_ARM_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    (arm_q && arm_age_q != WIN_LAST && !arm_touch) |=> arm_q)
    else $error("arm flag cleared before its 12 clocks");

  AST_REFRESH_LOAD: assert property (@(posedge mclk) disable iff (!rst_n)
    refresh |=> (cnt_q == {1'b0, $past(reload_q[6:0]), 8'h00} && !arm_q))
    else $error("refresh did not reload counter or clear arm");

  AST_START_LIFE: assert property (@(posedge mclk) disable iff (!rst_n)
    (start_q && start_age_q == WIN_LAST && !start_touch) |=> !start_q)
    else $error("start flag outlived its 12 clocks");

  AST_START_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    (start_q && start_age_q != WIN_LAST && !start_touch) |=> start_q)
    else $error("start flag cleared before its 12 clocks");

  AST_RELOAD_RW: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_rel ##1 (bus_req.rd && bus_req.addr == `SWD_OFF_RELOAD && !wr_rel) |=>
      bus_rdata == $past(reload_q))
    else $error("reload register readback wrong");

  AST_IRQ: assert property (@(posedge mclk) disable iff (!rst_n)
    |(status_q & mask_q) |-> irq)
    else $error("unmasked event without interrupt");

  CV_START: cover property (@(posedge mclk) disable iff (!rst_n)
    run_q == SWD_STOPPED && start_set);
  CV_REFRESH: cover property (@(posedge mclk) disable iff (!rst_n) refresh);
  CV_MISSED: cover property (@(posedge mclk) disable iff (!rst_n) arm_expire);
  CV_TIMEOUT: cover property (@(posedge mclk) disable iff (!rst_n) $rose(wd_timeout));

endmodule
